// ==== rtl/coprocessor_interface.sv ====
`timescale 1ns/10ps
`default_nettype none
module coprocessor_interface
  import cp_port_pkg::*;
(
  input  wire logic        ref_clk,               // 20 MHz clock
  input  wire logic        srst,                  // Sync reset, high
  input  wire logic        fetch_req,             // Pipeline fetch this cycle
  input  wire logic [31:0] fetch_addr,            // Fetch address
  input  wire decode_req_s dec_req,               // Instruction at decode
  input  wire logic        other_trap,            // Trap from elsewhere
  input  wire logic        coproc_present_n,      // Presence, low
  input  wire logic        pipeline_freeze_n,     // Freeze, low
  input  wire logic        coproc_exception_n,    // Exception, low
  input  wire logic [1:0]  coproc_cond_code,      // Condition code
  input  wire logic        cond_code_valid,       // Condition valid
  output logic             fetch_indicator,       // Fetch flag
  output logic             issue_strobe_a,        // Issue strobe one
  output logic             issue_strobe_b,        // Issue strobe two
  output logic             exception_acknowledge, // Exception ack
  output logic             flush,                 // Trap flush
  output logic [31:0]      mem_addr,              // Address bus
  output logic             pipe_stall,            // Pipeline held
  output logic             dec_accept,            // Decode slot taken
  output exec_res_s        exec_res               // Execute result
);

  ////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for the coprocessor pins
  logic [4:0] sync1_ff;
  logic [4:0] sync2_ff;
  wire  [4:0] pins_in = {coproc_present_n, pipeline_freeze_n,
                         coproc_exception_n, cond_code_valid,
                         1'b0};
  logic [1:0] cc1_ff;
  logic [1:0] cc2_ff;

  // Pin capture
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sync1_ff <= 5'h0e;
      sync2_ff <= 5'h0e;
      cc1_ff   <= 2'h0;
      cc2_ff   <= 2'h0;
    end else begin
      sync1_ff <= pins_in;
      sync2_ff <= sync1_ff;
      cc1_ff   <= coproc_cond_code;
      cc2_ff   <= cc1_ff;
    end
  end

  // Synchronised levels
  wire present  = ~sync2_ff[4];
  wire freeze   = ~sync2_ff[3];
  wire exc_line = ~sync2_ff[2];
  wire cc_ok    = sync2_ff[1];

  ////////////////////////////////////////////////////////////////////////
  // Pipeline registers
  decode_req_s ex_ff;
  logic        exc_pend_ff;
  logic        exc_prev_ff;
  logic        fetch_ind_ff;
  logic        ins_a_ff;
  logic        ins_b_ff;
  logic        xack_ff;
  logic        flush_ff;
  logic [31:0] addr_ff;
  logic        stall_ff;
  logic        acc_ff;
  exec_res_s   res_ff;

  // Stall on freeze or invalid condition codes
  wire stall = freeze | ~cc_ok;

  // Decode of the instruction at decode stage
  wire dec_is_cp = dec_req.valid & (dec_req.cls != CLS_OTHER);

  // Execute-stage classification
  wire ex_is_cp  = ex_ff.valid & (ex_ff.cls != CLS_OTHER);
  wire ex_dis    = ex_is_cp & ~present;
  wire ex_exc    = ex_is_cp & present & exc_pend_ff;
  // Outside traps are never lost, even while frozen
  wire ex_trap   = other_trap | (~stall & (ex_dis | ex_exc));
  // No retake while the source still sees its late accept
  wire dec_go    = dec_req.valid & ~stall & ~res_ff.trap & ~acc_ff &
                   ~ex_trap;
  wire br_taken;

  cp_branch_eval u_branch (
    .cond_code (cc2_ff),
    .cond      (ex_ff.cond),
    .taken     (br_taken)
  );

  // Next values
  wire         nxt_ins_a = dec_go & dec_is_cp & ~dec_req.issue_b;
  wire         nxt_ins_b = dec_go & dec_is_cp & dec_req.issue_b;
  wire         nxt_xack  = ex_exc & ~stall;
  wire         nxt_ldst  = ex_ff.valid & ~stall & (ex_ff.cls == CLS_LDST);
  wire [31:0]  nxt_addr  = nxt_ldst ? ex_ff.addr : fetch_addr;
  wire [7:0]   nxt_tt    = ex_dis ? TT_CP_DISABLED :
                           (ex_exc ? TT_CP_EXCEPTION : TT_RESET_VAL);
  wire         nxt_br    = ~stall & ex_ff.valid &
                           (ex_ff.cls == CLS_BRANCH) & br_taken;

  // Exception pending flag: rising edge of the sampled line latched, consumed by the trap
  // Rising edge only: the line stays low until the ack has been seen
  wire exc_rise     = exc_line & ~exc_prev_ff;
  wire nxt_exc_pend = exc_rise | (exc_pend_ff & ~nxt_xack);

  // Pipeline and strobe registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ex_ff        <= '0;
      exc_pend_ff  <= 1'b0;
      exc_prev_ff  <= 1'b0;
      fetch_ind_ff <= 1'b0;
      ins_a_ff     <= 1'b0;
      ins_b_ff     <= 1'b0;
      xack_ff      <= 1'b0;
      flush_ff     <= 1'b0;
      addr_ff      <= 32'h0000_0000;
      stall_ff     <= 1'b0;
      acc_ff       <= 1'b0;
      res_ff       <= '0;
    end else begin
      if (ex_trap) begin
        ex_ff <= '0;
      end else if (~stall) begin
        ex_ff <= dec_go ? dec_req : '0;
      end
      exc_pend_ff  <= nxt_exc_pend;
      exc_prev_ff  <= exc_line;
      fetch_ind_ff <= fetch_req & ~stall;
      ins_a_ff     <= nxt_ins_a;
      ins_b_ff     <= nxt_ins_b;
      xack_ff      <= nxt_xack;
      flush_ff     <= ex_trap;
      addr_ff      <= nxt_addr;
      stall_ff     <= stall;
      acc_ff       <= dec_go;
      res_ff       <= '{trap: ex_trap, trap_type: nxt_tt,
                        branch_taken: nxt_br};
    end
  end

  // Outputs straight from flip-flops
  assign fetch_indicator       = fetch_ind_ff;
  assign issue_strobe_a        = ins_a_ff;
  assign issue_strobe_b        = ins_b_ff;
  assign exception_acknowledge = xack_ff;
  assign flush                 = flush_ff;
  assign mem_addr              = addr_ff;
  assign pipe_stall            = stall_ff;
  assign dec_accept            = acc_ff;
  assign exec_res              = res_ff;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_disabled_trap;
    @(posedge ref_clk) disable iff (srst)
      (ex_dis && !stall) |=> (res_ff.trap && res_ff.trap_type == 8'h24);
  endproperty
  a_disabled_trap: assert property (p_disabled_trap)
    else $error("disabled trap missing");

  property p_freeze_stalls;
    @(posedge ref_clk) disable iff (srst)
      freeze |=> (pipe_stall && !dec_accept && !issue_strobe_a);
  endproperty
  a_freeze_stalls: assert property (p_freeze_stalls)
    else $error("pipeline ran during freeze");

  property p_ccv_stalls;
    @(posedge ref_clk) disable iff (srst)
      !cc_ok |=> (pipe_stall && !exec_res.branch_taken);
  endproperty
  a_ccv_stalls: assert property (p_ccv_stalls)
    else $error("ran with invalid condition codes");

  property p_issue;
    @(posedge ref_clk) disable iff (srst)
      (dec_go && dec_is_cp) |=> (issue_strobe_a ^ issue_strobe_b);
  endproperty
  a_issue: assert property (p_issue)
    else $error("issue strobe missing");

  property p_no_issue;
    @(posedge ref_clk) disable iff (srst)
      !(dec_go && dec_is_cp) |=> !(issue_strobe_a || issue_strobe_b);
  endproperty
  a_no_issue: assert property (p_no_issue)
    else $error("stray issue strobe");

  property p_xack_flush;
    @(posedge ref_clk) disable iff (srst)
      exception_acknowledge |-> (flush && exec_res.trap_type == 8'h28);
  endproperty
  a_xack_flush: assert property (p_xack_flush)
    else $error("ack without exception trap");

  property p_first_sample;
    @(posedge ref_clk) disable iff (srst)
      (!ex_is_cp ##1 !ex_is_cp) |-> !exception_acknowledge;
  endproperty
  a_first_sample: assert property (p_first_sample)
    else $error("exception taken without coprocessor instruction");

  property p_flush;
    @(posedge ref_clk) disable iff (srst)
      other_trap |=> flush;
  endproperty
  a_flush: assert property (p_flush)
    else $error("trap without flush");

  property p_fetch;
    @(posedge ref_clk) disable iff (srst)
      (fetch_req && !stall) |=> fetch_indicator;
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("fetch not flagged");

  property p_ldst_addr;
    @(posedge ref_clk) disable iff (srst)
      nxt_ldst |=> (mem_addr == $past(ex_ff.addr));
  endproperty
  a_ldst_addr: assert property (p_ldst_addr)
    else $error("load/store address wrong");

  property p_branch;
    @(posedge ref_clk) disable iff (srst)
      (!stall && ex_ff.valid && ex_ff.cls == CLS_BRANCH)
        |=> (exec_res.branch_taken == $past(ex_ff.cond[cc2_ff]));
  endproperty
  a_branch: assert property (p_branch)
    else $error("branch resolved wrong");

endmodule
`default_nettype wire

// ==== shared/cp_port_pkg.sv ====
// Function
// - Every fetch is flagged on one fetch indicator shared by both coprocessor ports; here a fetch made while stalled is not flagged.
// - Integer unit decodes all, hands coprocessor instructions on; both run concurrently.
// - An issue strobe rises at decode start of each coprocessor instruction; here it rises the cycle after decode accepts it.
// - Presence must be low; a coprocessor instruction with it high traps as disabled.
// - The pipeline stays frozen while the freeze input is low.
// - Exception acknowledged at execute of the next coprocessor instruction, in the same cycle as its trap.
// - Coprocessor branches resolve from the two-bit condition code.
// - Execution halts while condition valid is low.
// - Integer unit drives the address of coprocessor loads and stores.
// - Any trap pulses flush; coprocessor drops decode buffers, keeps its queue.
// - Exception is not taken when first sampled; it waits for a coprocessor instruction.
package cp_port_pkg;

  // Instruction classes presented at decode
  typedef enum logic [2:0] {
    CLS_OTHER   = 3'h0,
    CLS_COPROC_OPERATE_INSTR    = 3'h1,
    CLS_COMPARE = 3'h2,
    CLS_BRANCH  = 3'h3,
    CLS_LDST    = 3'h4
  } instr_class_e;

  // Trap types raised by this block
  localparam logic [7:0] TT_CP_DISABLED  = 8'h24;
  localparam logic [7:0] TT_CP_EXCEPTION = 8'h28;
  localparam logic [7:0] TT_RESET_VAL    = 8'h00;

  // Instruction presented by the pipeline
  typedef struct packed {
    logic         valid;
    instr_class_e cls;
    logic         issue_b;
    logic [3:0]   cond;
    logic [31:0]  addr;
  } decode_req_s;

  // Result of one execute step
  typedef struct packed {
    logic       trap;
    logic [7:0] trap_type;
    logic       branch_taken;
  } exec_res_s;

endpackage

// ==== rtl/cp_branch_eval.sv ====
`timescale 1ns/10ps
`default_nettype none
module cp_branch_eval
  import cp_port_pkg::*;
(
  input  wire logic [1:0] cond_code, // Synchronised condition code
  input  wire logic [3:0] cond,      // Branch condition field
  output logic            taken      // Branch resolves taken
);
  // Condition field picks the codes for which the branch is taken
  assign taken = cond[cond_code];
endmodule
`default_nettype wire

// ==== tb/cp_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module cp_model (
  input  wire logic       ref_clk,    // Clock
  input  wire logic       srst,       // Reset
  input  wire logic       fetch_ind,  // Fetch flag
  input  wire logic       strobe,     // Any issue
  input  wire logic       flush,      // Trap flush
  input  wire logic       ack,        // Exception ack
  input  wire logic       absent,     // Play absent
  input  wire logic       freeze_req, // Ask freeze
  input  wire logic       exc_req,    // Raise exception
  input  wire logic       cmp_busy,   // Compare running
  input  wire logic [1:0] cc_in,      // Compare result
  output logic            present_n,  // Presence
  output logic            freeze_n,   // Freeze
  output logic            exc_n,      // Exception
  output logic [1:0]      cc,         // Condition code
  output logic            ccv         // Codes valid
);
  logic [3:0] n_buf_ff; // Fetched words held
  logic [3:0] n_q_ff;   // Queue entries
  logic       exc_ff;   // Exception latched
  logic [31:0] regs_ff [32]; // Working registers
  logic [31:0] state_ff;     // Status, reached through memory only
  ////////////////////////////////////////////////////////////////////
  // Buffer fetches, queue on issue, flush spares queue
  always_ff @(posedge ref_clk) begin
    if (srst || flush)
      n_buf_ff <= '0;
    else if (fetch_ind)
      n_buf_ff <= n_buf_ff + 4'h1;
    if (srst)
      n_q_ff <= '0;
    else if (strobe)
      n_q_ff <= n_q_ff + 4'h1;
    else if (n_q_ff != 4'h0)
      n_q_ff <= n_q_ff - 4'h1;
    if (srst || ack)
      exc_ff <= 1'b0;
    else if (exc_req)
      exc_ff <= 1'b1;
    // Operate results land in the working file
    if (strobe)
      regs_ff[{1'b0, n_buf_ff}] <= {28'h000_0000, n_q_ff};
    state_ff <= {31'h0000_0000, exc_ff};
  end
  // Pins toward the integer unit
  assign present_n = absent;
  assign freeze_n  = !(freeze_req || n_q_ff == 4'hF);
  assign exc_n     = !exc_ff;
  assign ccv       = !cmp_busy;
  assign cc        = cc_in;
endmodule
`default_nettype wire

// ==== tb/coprocessor_interface_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module coprocessor_interface_tb;
  import cp_port_pkg::*;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic        fetch_req = 1'b0;
  logic [31:0] fetch_addr = '0;
  decode_req_s dec_req = '0;
  logic        other_trap = 1'b0;
  logic        absent = 1'b0, freeze_req = 1'b0, exc_req = 1'b0;
  logic        cmp_busy = 1'b0;
  logic [1:0]  cc_in = '0, cc;
  logic        pn, fn, en, ccv, fi, sa, sb, ack, fl, stall, acc;
  logic [31:0] ma, want_ad;
  exec_res_s   er;
  logic        g_fi, g_a, g_b, g_ack, g_fl, g_tr, g_tk, g_ad, g_acc;
  logic [7:0]  g_tt;
  int          fails = 0, n_checks = 0, cyc = 0;
  ////////////////////////////////////////////////////////////////////
  // Clock, device and far side
  always #25 ref_clk = ~ref_clk;
  coprocessor_interface dut (.ref_clk(ref_clk), .srst(srst),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr), .dec_req(dec_req),
    .other_trap(other_trap), .coproc_present_n(pn),
    .pipeline_freeze_n(fn), .coproc_exception_n(en),
    .coproc_cond_code(cc), .cond_code_valid(ccv), .fetch_indicator(fi),
    .issue_strobe_a(sa), .issue_strobe_b(sb),
    .exception_acknowledge(ack), .flush(fl), .mem_addr(ma),
    .pipe_stall(stall), .dec_accept(acc), .exec_res(er));
  cp_model cp (.ref_clk(ref_clk), .srst(srst), .fetch_ind(fi),
    .strobe(sa | sb), .flush(fl), .ack(ack), .absent(absent),
    .freeze_req(freeze_req), .exc_req(exc_req), .cmp_busy(cmp_busy),
    .cc_in(cc_in), .present_n(pn), .freeze_n(fn), .exc_n(en), .cc(cc),
    .ccv(ccv));
  ////////////////////////////////////////////////////////////////////
  // Checking and sampling helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic clr();
    {g_fi, g_a, g_b, g_ack, g_fl, g_tr, g_tk, g_ad, g_acc} = '0;
    g_tt = '0;
  endtask
  task automatic collect(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      if (g_acc) dec_req.valid <= 1'b0;
      #1;
      g_fi |= fi;
      g_a |= sa;
      g_b |= sb;
      g_ack |= ack;
      g_fl |= fl;
      g_acc |= acc;
      g_ad |= (ma === want_ad);
      g_tk |= er.branch_taken;
      if (er.trap === 1'b1) begin
        g_tr = 1'b1;
        g_tt = er.trap_type;
      end
    end
  endtask
  task automatic start(input instr_class_e c, input logic b,
                       input logic [3:0] cd, input logic [31:0] ad);
    clr();
    want_ad = ad;
    @(posedge ref_clk);
    dec_req <= '{1'b1, c, b, cd, ad};
  endtask
  task automatic finish();
    for (int k = 0; k < 20 && !g_acc; k++)
      collect(1);
    collect(3);
    chk(g_acc, 1'b1);
  endtask
  task automatic send(input instr_class_e c, input logic b,
                      input logic [3:0] cd, input logic [31:0] ad);
    start(c, b, cd, ad);
    finish();
  endtask
  ////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_fetch();
    clr();
    want_ad = 32'h0000_1234;
    @(posedge ref_clk);
    fetch_req <= 1'b1;
    fetch_addr <= 32'h0000_1234;
    collect(3);
    chk(g_fi, 1'b1);
    chk(g_ad, 1'b1);
    @(posedge ref_clk);
    fetch_req <= 1'b0;
  endtask
  task automatic t_issue();
    send(CLS_COPROC_OPERATE_INSTR, 1'b0, 4'h0, 32'h0);
    chk({g_a, g_b, g_tr}, 3'b100);
    send(CLS_COPROC_OPERATE_INSTR, 1'b1, 4'h0, 32'h0);
    chk({g_a, g_b, g_tr}, 3'b010);
    send(CLS_OTHER, 1'b0, 4'h0, 32'h0);
    chk({g_a, g_b}, 2'b00);
  endtask
  task automatic t_absent();
    @(posedge ref_clk);
    absent <= 1'b1;
    collect(4);
    send(CLS_COPROC_OPERATE_INSTR, 1'b0, 4'h0, 32'h0);
    chk({g_tr, g_fl, g_tt}, {2'b11, TT_CP_DISABLED});
    @(posedge ref_clk);
    absent <= 1'b0;
    collect(4);
  endtask
  task automatic t_exc();
    @(posedge ref_clk);
    exc_req <= 1'b1;
    @(posedge ref_clk);
    exc_req <= 1'b0;
    collect(4);
    send(CLS_OTHER, 1'b0, 4'h0, 32'h0);
    chk({g_ack, g_tr}, 2'b00);
    send(CLS_COPROC_OPERATE_INSTR, 1'b0, 4'h0, 32'h0);
    chk({g_ack, g_fl, g_tt}, {2'b11, TT_CP_EXCEPTION});
    collect(4);
  endtask
  task automatic t_trap();
    clr();
    @(posedge ref_clk);
    other_trap <= 1'b1;
    @(posedge ref_clk);
    other_trap <= 1'b0;
    #1;
    g_fl = fl;
    g_ack = ack;
    collect(3);
    chk({g_fl, g_ack}, 2'b10);
  endtask
  task automatic t_ldst();
    send(CLS_LDST, 1'b0, 4'h0, 32'h0000_2468);
    chk(g_ad, 1'b1);
  endtask
  task automatic t_branch();
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      cc_in <= i[1:0];
      collect(4);
      send(CLS_BRANCH, 1'b0, 4'h5, 32'h0);
      chk(g_tk, i[0] == 1'b0);
    end
  endtask
  task automatic t_hold(input logic use_ccv);
    if (use_ccv)
      send(CLS_COMPARE, 1'b0, 4'h0, 32'h0);
    @(posedge ref_clk);
    cmp_busy <= use_ccv;
    freeze_req <= !use_ccv;
    collect(4);
    start(use_ccv ? CLS_OTHER : CLS_COPROC_OPERATE_INSTR, 1'b0, 4'h0, 32'h0);
    collect(5);
    chk({g_acc, stall}, 2'b01);
    @(posedge ref_clk);
    {cmp_busy, freeze_req} <= 2'b00;
    finish();
    if (use_ccv) begin
      send(CLS_BRANCH, 1'b0, 4'h8, 32'h0);
      chk(g_tk, 1'b1);
    end
  endtask
  ////////////////////////////////////////////////////////////////////
  // Cycle ceiling
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      test_done();
    end
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    collect(3);
    t_fetch();
    t_issue();
    t_ldst();
    t_branch();
    t_hold(1'b0);
    t_hold(1'b1);
    t_absent();
    t_exc();
    t_trap();
    test_done();
  end
endmodule
`default_nettype wire
